// >>> rtl/ics_slave.sv
// command slave port: address match, command pointer, byte writes and reads
// assumes the master keeps bus timing; pins are open drain, released high
`timescale 1ns/1ps
module ics_slave #(
    parameter int           TIMEOUT_CYC   = ics_pkg::TOUT_CYC,
    parameter logic [7:0]   FAULT_CLR_CMD = ics_pkg::FAULT_CLR_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_n,
    input  wire logic [6:0]       dev_addr,
    input  wire logic             timeout_en,
    output logic [7:0]            cmd_ptr,
    output logic                  wr_valid,
    output ics_pkg::ics_wr_s      wr,
    output logic                  rd_req,
    input  wire logic [15:0]      rd_data,
    output logic                  fault_clear
);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] TOUT_END = TW'(TIMEOUT_CYC);

    ics_pkg::ics_bus_s   bus;
    ics_pkg::ics_state_e state;
    ics_pkg::ics_state_e next_state;
    logic [3:0]          bitcnt;
    logic [3:0]          next_bitcnt;
    logic [7:0]          shift;
    logic [7:0]          next_shift;
    logic [7:0]          tx;
    logic [7:0]          next_tx;
    logic                rw;
    logic                next_rw;
    logic [7:0]          next_cmd_ptr;
    logic [7:0]          wr_cnt;
    logic [7:0]          next_wr_cnt;
    logic [1:0]          rd_idx;
    logic [1:0]          next_rd_idx;
    logic                next_sda_oe_n;
    logic                next_wr_valid;
    ics_pkg::ics_wr_s    next_wr;
    logic                next_rd_req;
    logic                next_fault_clear;
    logic [TW-1:0]       tout;
    logic [TW-1:0]       next_tout;

    // read byte by index, low byte first, padding past the word
    function automatic logic [7:0] pick_byte(input logic [15:0] d, input logic [1:0] i);
        if (i == 2'h0) begin
            pick_byte = d[7:0];
        end else if (i == 2'h1) begin
            pick_byte = d[15:8];
        end else begin
            pick_byte = ics_pkg::RD_PAD;
        end
    endfunction : pick_byte

    ics_pin_sync u_sync (
        .clk   (clk),
        .rst   (rst),
        .scl_i (scl_i),
        .sda_i (sda_i),
        .bus   (bus)
    );

    // open drain: only ever pull low
    assign sda_o = 1'b0;

    // protocol sequencer
    always_comb begin
        next_state       = state;
        next_bitcnt      = bitcnt;
        next_shift       = shift;
        next_tx          = tx;
        next_rw          = rw;
        next_cmd_ptr     = cmd_ptr;
        next_wr_cnt      = wr_cnt;
        next_rd_idx      = rd_idx;
        next_sda_oe_n    = sda_oe_n;
        next_wr_valid    = 1'b0;
        next_wr          = wr;
        next_rd_req      = 1'b0;
        next_fault_clear = 1'b0;
        if (state == ics_pkg::ST_IDLE || bus.scl_rise || bus.scl_fall || bus.start || bus.stop) begin
            next_tout = '0;
        end else if (tout != TOUT_END) begin
            next_tout = tout + TW'(1);
        end else begin
            next_tout = tout;
        end
        if (bus.start) begin
            // start keeps the pointer; direction retaken
            next_state    = ics_pkg::ST_ADDR;
            next_bitcnt   = 4'h0;
            next_sda_oe_n = 1'b1;
        end else if (bus.stop) begin
            // send byte with fault clear command
            if (state == ics_pkg::ST_WR_BYTE && wr_cnt == 8'h01 && cmd_ptr == FAULT_CLR_CMD) begin
                next_fault_clear = 1'b1;
            end
            next_state    = ics_pkg::ST_IDLE;
            next_sda_oe_n = 1'b1;
        end else if (timeout_en && tout == TOUT_END) begin
            next_state    = ics_pkg::ST_IDLE;
            next_sda_oe_n = 1'b1;
        end else begin
            case (state)
                ics_pkg::ST_ADDR, ics_pkg::ST_WR_BYTE: begin
                    if (bus.scl_rise && bitcnt != ics_pkg::BYTE_BITS) begin
                        next_shift  = {shift[6:0], bus.sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (bus.scl_fall && bitcnt == ics_pkg::BYTE_BITS) begin
                        if (state == ics_pkg::ST_ADDR) begin
                            if (shift[7:1] == dev_addr) begin
                                next_state    = ics_pkg::ST_ADDR_ACK;
                                next_sda_oe_n = 1'b0;
                                next_rw       = shift[0];
                                next_wr_cnt   = 8'h00;
                                next_rd_idx   = 2'h0;
                                next_rd_req   = shift[0];
                            end else begin
                                next_state = ics_pkg::ST_IDLE;
                            end
                        end else begin
                            next_state    = ics_pkg::ST_WR_ACK;
                            next_sda_oe_n = 1'b0;
                            if (wr_cnt != ics_pkg::WR_CNT_MAX) begin
                                next_wr_cnt = wr_cnt + 8'h01;
                            end
                            if (wr_cnt == 8'h00) begin
                                next_cmd_ptr = shift;
                            end else begin
                                // data bytes indexed in arrival order
                                next_wr_valid = 1'b1;
                                next_wr       = '{cmd: cmd_ptr, idx: wr_cnt - 8'h01, data: shift};
                            end
                        end
                    end
                end
                ics_pkg::ST_ADDR_ACK: begin
                    if (bus.scl_fall) begin
                        next_bitcnt = 4'h0;
                        if (rw) begin
                            next_tx       = pick_byte(rd_data, 2'h0);
                            next_sda_oe_n = rd_data[7];
                            next_rd_idx   = 2'h1;
                            next_state    = ics_pkg::ST_RD_BYTE;
                        end else begin
                            next_sda_oe_n = 1'b1;
                            next_state    = ics_pkg::ST_WR_BYTE;
                        end
                    end
                end
                ics_pkg::ST_WR_ACK: begin
                    if (bus.scl_fall) begin
                        next_sda_oe_n = 1'b1;
                        next_bitcnt   = 4'h0;
                        next_state    = ics_pkg::ST_WR_BYTE;
                    end
                end
                ics_pkg::ST_RD_BYTE: begin
                    if (bus.scl_rise) begin
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (bus.scl_fall) begin
                        // data moves only after the clock falls
                        if (bitcnt == ics_pkg::BYTE_BITS) begin
                            next_sda_oe_n = 1'b1;
                            next_state    = ics_pkg::ST_RD_ACK;
                        end else begin
                            next_tx       = {tx[6:0], 1'b0};
                            next_sda_oe_n = tx[6];
                        end
                    end
                end
                ics_pkg::ST_RD_ACK: begin
                    if (bus.scl_rise && bus.sda) begin
                        next_state = ics_pkg::ST_IDLE;
                    end else if (bus.scl_fall) begin
                        next_tx       = pick_byte(rd_data, rd_idx);
                        next_sda_oe_n = next_tx[7];
                        next_bitcnt   = 4'h0;
                        if (rd_idx != ics_pkg::RD_IDX_MAX) begin
                            next_rd_idx = rd_idx + 2'h1;
                        end
                        next_state = ics_pkg::ST_RD_BYTE;
                    end
                end
                default: begin
                    next_state    = ics_pkg::ST_IDLE;
                    next_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state       <= ics_pkg::ST_IDLE;
            bitcnt      <= 4'h0;
            shift       <= 8'h00;
            tx          <= 8'h00;
            rw          <= 1'b0;
            cmd_ptr     <= ics_pkg::CMD_RST;
            wr_cnt      <= 8'h00;
            rd_idx      <= 2'h0;
            sda_oe_n    <= 1'b1;
            wr_valid    <= 1'b0;
            wr          <= '0;
            rd_req      <= 1'b0;
            fault_clear <= 1'b0;
            tout        <= '0;
        end else begin
            state       <= next_state;
            bitcnt      <= next_bitcnt;
            shift       <= next_shift;
            tx          <= next_tx;
            rw          <= next_rw;
            cmd_ptr     <= next_cmd_ptr;
            wr_cnt      <= next_wr_cnt;
            rd_idx      <= next_rd_idx;
            sda_oe_n    <= next_sda_oe_n;
            wr_valid    <= next_wr_valid;
            wr          <= next_wr;
            rd_req      <= next_rd_req;
            fault_clear <= next_fault_clear;
            tout        <= next_tout;
        end
    end

    // checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_idle_released: assert property (state == ics_pkg::ST_IDLE |-> sda_oe_n)
        else $error("data line held while idle");
    chk_drive_clk_low: assert property ($fell(sda_oe_n) |-> !bus.scl)
        else $error("data pulled low with clock high");
    chk_addr_nomatch: assert property (state == ics_pkg::ST_ADDR && bus.scl_fall && bitcnt == 4'h8 && !bus.start
        && !bus.stop && shift[7:1] != dev_addr |=> state == ics_pkg::ST_IDLE && sda_oe_n)
        else $error("foreign address not ignored");
    chk_addr_ack: assert property (state == ics_pkg::ST_ADDR && bus.scl_fall && bitcnt == 4'h8 && !bus.start
        && !bus.stop && shift[7:1] == dev_addr |=> !sda_oe_n && rw == $past(shift[0]))
        else $error("own address not acknowledged");
    chk_cmd_store: assert property (state == ics_pkg::ST_WR_BYTE && bus.scl_fall && bitcnt == 4'h8
        && !bus.start && !bus.stop && wr_cnt == 8'h00 |=> cmd_ptr == $past(shift) && !wr_valid)
        else $error("command byte not stored");
    chk_data_event: assert property (state == ics_pkg::ST_WR_BYTE && bus.scl_fall && bitcnt == 4'h8
        && !bus.start && !bus.stop && wr_cnt != 8'h00 |=> wr_valid && wr.data == $past(shift)
        && wr.idx == $past(wr_cnt) - 8'h01)
        else $error("data byte not delivered");
    chk_wr_ack: assert property (state == ics_pkg::ST_WR_ACK |-> !sda_oe_n)
        else $error("written byte not acknowledged");
    chk_fault_clear: assert property (bus.stop && state == ics_pkg::ST_WR_BYTE && wr_cnt == 8'h01
        && cmd_ptr == FAULT_CLR_CMD |=> fault_clear ##1 !fault_clear)
        else $error("fault clear not pulsed");
    chk_read_nack: assert property (state == ics_pkg::ST_RD_ACK && bus.scl_rise && bus.sda && !bus.start
        && !bus.stop |=> state == ics_pkg::ST_IDLE)
        else $error("read not ended on nack");
    chk_low_first: assert property (state == ics_pkg::ST_ADDR_ACK && bus.scl_fall && rw && !bus.start
        && !bus.stop |=> tx == $past(rd_data[7:0]) && sda_oe_n == $past(rd_data[7]))
        else $error("low byte not sent first");
    chk_read_dir: assert property (state == ics_pkg::ST_RD_BYTE |-> rw)
        else $error("read without read direction");
    chk_ptr_kept: assert property (bus.start |=> cmd_ptr == $past(cmd_ptr))
        else $error("pointer lost on start");
    chk_timeout: assert property (timeout_en && tout == TOUT_END && !bus.start && !bus.stop
        |=> state == ics_pkg::ST_IDLE && sda_oe_n)
        else $error("locked bus not released");

    cov_word_write: cover property (wr_valid && wr.idx == 8'h01);
    cov_read_byte: cover property (state == ics_pkg::ST_RD_ACK ##1 state == ics_pkg::ST_IDLE);
    cov_fault_clear: cover property (fault_clear);
    cov_rep_start: cover property (state == ics_pkg::ST_WR_BYTE && bus.start);

endmodule : ics_slave

// >>> rtl/ics_pkg.sv
// shared constants, states and carriers of the two-wire command slave port
// assumes a single 100 MHz core clock; bus pins arrive asynchronously
package ics_pkg;

    // core clock and bus timeout
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          TOUT_MS       = 35;
    localparam int          TOUT_CYC      = TOUT_MS * (CLK_HZ / 1000);

    // byte framing: eight data bits then one acknowledge bit
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [7:0]  WR_CNT_MAX    = 8'hFF;
    localparam logic [1:0]  RD_IDX_MAX    = 2'h2;
    localparam logic [7:0]  RD_PAD        = 8'hFF;

    // reset values and defaults
    localparam logic [7:0]  CMD_RST       = 8'h00;
    localparam logic [7:0]  FAULT_CLR_DEF = 8'h03;
    localparam logic [6:0]  DEV_ADDR_DEF  = 7'h40;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } ics_state_e;

    // synchronised bus view with detected events
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } ics_bus_s;

    // one received data byte bound for the selected register
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] idx;
        logic [7:0] data;
    } ics_wr_s;

endpackage : ics_pkg

// >>> rtl/ics_pin_sync.sv
// two-flop synchroniser for clock and data pins with edge and condition detect
// assumes pins are asynchronous to clk and far slower than it
`timescale 1ns/1ps
module ics_pin_sync (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output ics_pkg::ics_bus_s     bus
);
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
    logic [1:0] next_meta;
    logic [1:0] next_sync;
    logic [1:0] next_prev;

    // shift pins through meta, sync and history stages
    always_comb begin
        next_meta = {scl_i, sda_i};
        next_sync = meta;
        next_prev = sync;
    end

    // registers released high like an idle bus
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 2'h3;
            sync <= 2'h3;
            prev <= 2'h3;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // events only look at the second and third stages; one driver for the whole carrier
    assign bus = '{
        scl:      sync[1],
        sda:      sync[0],
        scl_rise: sync[1] & ~prev[1],
        scl_fall: ~sync[1] & prev[1],
        start:    sync[1] & prev[1] & ~sync[0] & prev[0],
        stop:     sync[1] & prev[1] & sync[0] & ~prev[0]
    };

endmodule : ics_pin_sync

// >>> sim/ics_bus_master.sv
// bus master model: open-drain clock and data driver for the command slave port
// assumes pull-ups on both lines; the bench calls its tasks through the instance
`timescale 1ns/1ps
module ics_bus_master (
    input  wire logic sda,
    output logic      scl,
    output logic      sda_rel
);
    // quarter of the 80 ns bus clock period; clock stands high outside frames
    localparam time Q = 20;

    // both lines released at time zero
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic bit_clk(input logic b, output logic seen);
        #Q sda_rel = b;
        #Q scl = 1'b1;
        #Q seen = sda;
        #Q scl = 1'b0;
    endtask : bit_clk

    task automatic send_bits(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(b[i], s);
        end
    endtask : send_bits

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        send_bits(b);
        bit_clk(1'b1, s);
        ack = ~s;
    endtask : write_byte

    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(1'b1, s);
            b[i] = s;
        end
        bit_clk(~ack, s);
    endtask : read_byte

    // new start fixes direction; extra low time lets the slave release its ack
    task automatic start_cond();
        #Q sda_rel = 1'b1;
        #(2 * Q) scl = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #Q sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #Q;
    endtask : stop_cond
endmodule : ics_bus_master

// >>> sim/testbench.sv
// self-checking bench for the command slave port: writes, reads, fault clear, timeout
// assumes the bus master model drives the link; both bus lines pulled up
`timescale 1ns/1ps
module testbench;
    localparam logic [6:0] DEV  = 7'h40;
    localparam logic [7:0] FCLR = ics_pkg::FAULT_CLR_DEF;
    logic             clk;
    logic             rst;
    logic [6:0]       dev_addr;
    logic             timeout_en;
    logic [15:0]      rd_data;
    logic             scl;
    logic             sda_rel;
    logic             sda_bus;
    logic             sda_o;
    logic             sda_oe_n;
    logic [7:0]       cmd_ptr;
    logic             wr_valid;
    ics_pkg::ics_wr_s wr;
    logic             rd_req;
    logic             fault_clear;
    logic [23:0]      wq[$];
    int               n_fc = 0;
    int               n_rd = 0;
    int               mismatches = 0;
    int               checked = 0;

    // wired-and of master and device on the data line
    assign sda_bus = sda_rel & (sda_oe_n ? 1'b1 : sda_o);

    ics_slave #(.TIMEOUT_CYC(200), .FAULT_CLR_CMD(FCLR)) dut_u (
        .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .dev_addr(dev_addr), .timeout_en(timeout_en), .cmd_ptr(cmd_ptr), .wr_valid(wr_valid),
        .wr(wr), .rd_req(rd_req), .rd_data(rd_data), .fault_clear(fault_clear));
    ics_bus_master master_u (.sda(sda_bus), .scl(scl), .sda_rel(sda_rel));

    always #5 clk = ~clk;

    // register side: low byte is the pointer, high byte its inverse
    always @(posedge clk) rd_data <= #1 {~cmd_ptr, cmd_ptr};

    // collect strobes from the user side
    always @(posedge clk) begin
        if (wr_valid === 1'b1) wq.push_back(wr);
        if (fault_clear === 1'b1) n_fc++;
        if (rd_req === 1'b1) n_rd++;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // start or repeated start, then own address with direction bit
    task automatic open_xfer(input logic rd, output logic a);
        // launch just off a clock edge so the pins never move on it
        @(posedge clk);
        #1;
        master_u.start_cond();
        master_u.write_byte({DEV, rd}, a);
    endtask : open_xfer

    // command then n data bytes; n of zero is a send-byte
    task automatic t_write(input logic [7:0] cmd, input logic [7:0] d[4], input int n);
        logic a;
        int   na;
        na = 0;
        wq.delete();
        open_xfer(1'b0, a);
        na += a;
        master_u.write_byte(cmd, a);
        na += a;
        for (int i = 0; i < n; i++) begin
            master_u.write_byte(d[i], a);
            na += a;
        end
        master_u.stop_cond();
        repeat (10) @(posedge clk);
        chk(24'(na), 24'(n + 2));
        chk(cmd_ptr, cmd);
        chk(24'(wq.size()), 24'(n));
        for (int i = 0; i < n && i < wq.size(); i++) begin
            chk(wq[i], {cmd, 8'(i), d[i]});
        end
    endtask : t_write

    // command-only write, repeated start, then n read bytes
    task automatic t_read(input logic [7:0] cmd, input int n);
        logic       a;
        logic [7:0] b;
        int         na;
        int         r0;
        na = 0;
        r0 = n_rd;
        open_xfer(1'b0, a);
        na += a;
        master_u.write_byte(cmd, a);
        na += a;
        open_xfer(1'b1, a);
        na += a;
        for (int i = 0; i < n; i++) begin
            master_u.read_byte(i < n - 1, b);
            chk(b, i == 0 ? cmd : 8'(~cmd));
        end
        master_u.stop_cond();
        repeat (10) @(posedge clk);
        chk(24'(na), 24'h3);
        chk(24'(n_rd - r0), 24'h1);
        chk(cmd_ptr, cmd);
        chk(sda_oe_n, 1'b1);
    endtask : t_read

    // foreign address is never acknowledged and leaves the pointer alone
    task automatic t_bad();
        logic       a;
        logic       b;
        logic [7:0] p;
        p = cmd_ptr;
        wq.delete();
        #1;
        master_u.start_cond();
        master_u.write_byte({DEV ^ 7'h01, 1'b0}, a);
        master_u.write_byte(8'h21, b);
        master_u.stop_cond();
        repeat (10) @(posedge clk);
        chk({a, b}, 2'b00);
        chk(cmd_ptr, p);
        chk(24'(wq.size()), 24'h0);
    endtask : t_bad

    // only a send-byte with the clearing command pulses the clear
    task automatic t_fault();
        logic [7:0] z[4];
        int         f0;
        z = '{8'h11, 8'h00, 8'h00, 8'h00};
        f0 = n_fc;
        t_write(FCLR, z, 0);
        chk(24'(n_fc - f0), 24'h1);
        t_write(8'h04, z, 0);
        t_write(FCLR, z, 1);
        chk(24'(n_fc - f0), 24'h1);
    endtask : t_fault

    // master stalls while the device holds its ack low
    task automatic t_timeout(input logic en);
        logic a;
        @(posedge clk);
        #1 timeout_en = en;
        open_xfer(1'b0, a);
        master_u.send_bits(8'h30);
        repeat (300) @(posedge clk);
        #1;
        // master still holds the last command bit low, so judge the device's own drive
        chk(sda_oe_n, 24'(en));
        master_u.bit_clk(1'b1, a);
        master_u.stop_cond();
        @(posedge clk);
        #1 timeout_en = 1'b0;
    endtask : t_timeout

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        dev_addr = DEV;
        timeout_en = 1'b0;
        rd_data = 16'h0000;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        // master stays off the bus for a settle time
        repeat (5) @(posedge clk);
        chk(cmd_ptr, 8'h00);
        chk(sda_oe_n, 1'b1);
        t_write(8'h21, '{8'h5A, 8'h00, 8'h00, 8'h00}, 1);
        t_write(8'h22, '{8'hC3, 8'h81, 8'h00, 8'h00}, 2);
        t_write(8'h9E, '{8'h02, 8'hA5, 8'h3C, 8'h00}, 3);
        t_bad();
        t_read(8'h8B, 1);
        t_read(8'h8C, 2);
        t_fault();
        t_timeout(1'b0);
        t_timeout(1'b1);
        t_write(8'h7F, '{8'h01, 8'h80, 8'h00, 8'h00}, 2);
        wrap_up();
    end

    // watchdog well beyond the expected run of about 40 us
    initial begin
        #300_000;
        mismatches++;
        wrap_up();
    end
endmodule : testbench
